/* cv2_consts.svh */
`ifndef CV2_CONSTS_SVH
`define CV2_CONSTS_SVH
// Function
// (R1) Alternate select on: line four resets conditionally
// (R2) Alternate select off: line four reset ignored
// (R3) Bits 6:5 set drive strength, writable anytime
// (R4) Four-wide bit selects 4-4-4 or serial instructions
// (R5) Four-wide mode forces quad mode active
// (R6) Leaving four-wide mode keeps quad enable untouched
// (R7) Opcode 38h enters, F5h exits four-wide mode
// (R8) Both off: single/dual reads, protect and reset pins
// (R9) Quad enable only: quad reads, line three data
// (R10) Four-wide on: quad reads, line three data
// (R11) Bit 2 picks range or per-block protection
// (R12) Bit 1 read-only shows boot address length
// (R13) Bit 0 current address length, reset from nonvolatile
// (R14) B7h sets, E9h clears current address length
// (R15) Nonvolatile length rewrite also updates current length
// (R16) Reads 15h/65h, writes 01h/71h after 50h
// (R17) Wrap settings apply to main array reads only
// (R18) Resets copy nonvolatile config three to volatile
// (R19) Config three: 33h read, any-register, 77h write
// (R20) Mode switch completes within fixed latency
// (R21) Resets load writable fields from nonvolatile copy
// (R22) Reserved bit 4 reads zero, ignores writes
`define CV2_BIT_ALT_RESET 7
`define CV2_BIT_DRIVE_HI 6
`define CV2_BIT_DRIVE_LO 5
`define CV2_BIT_RESERVED 4
`define CV2_BIT_FOUR_WIDE 3
`define CV2_BIT_PROTECT 2
`define CV2_BIT_BOOT_ADDR 1
`define CV2_BIT_ADDR_CUR 0
`define CV2_NV_BIT_ADDR 1
`define CV2_CFG3_BIT_WRAP_OFF 4
`define CV2_CFG2_WRITE_MASK 8'hED
`define CV2_OP_READ_CFG2 8'h15
`define CV2_OP_READ_CFG3 8'h33
`define CV2_OP_READ_ANY 8'h65
`define CV2_OP_WRITE_ANY 8'h71
`define CV2_OP_WRITE_REGS 8'h01
`define CV2_OP_WREN_VOLATILE 8'h50
`define CV2_OP_BURST_LEN 8'h77
`define CV2_OP_ADDR4_ENTER 8'hB7
`define CV2_OP_ADDR4_EXIT 8'hE9
`define CV2_OP_WIDE_ENTER 8'h38
`define CV2_OP_WIDE_EXIT 8'hF5
`define CV2_READ_ANY_DUMMY 8'h08
`define CV2_REGADDR_CONFIG2 32'h00800003
`define CV2_REGADDR_CONFIG3 32'h00800004
`define CV2_ADDR_BYTES_3 3'h3
`define CV2_ADDR_BYTES_4 3'h4
`define CV2_WRR_IDX_CFG2 2'h2
`define CV2_WRR_IDX_CFG3 2'h3
`define CV2_LOCK_EDGE 2'h2
`endif

/* cv2_pkg.sv */
package cv2_pkg;
	typedef enum logic [5:0] {
		CV2_PH_INSTR = 6'h01,
		CV2_PH_ADDR = 6'h02,
		CV2_PH_DUMMY = 6'h04,
		CV2_PH_DATA = 6'h08,
		CV2_PH_READ = 6'h10,
		CV2_PH_IGNORE = 6'h20
	} cv2_phase_t;
	typedef enum logic [8:0] {
		CV2_ACT_NONE = 9'h001,
		CV2_ACT_WREN = 9'h002,
		CV2_ACT_CFG2 = 9'h004,
		CV2_ACT_CFG3 = 9'h008,
		CV2_ACT_BURST = 9'h010,
		CV2_ACT_ADDR4_ON = 9'h020,
		CV2_ACT_ADDR4_OFF = 9'h040,
		CV2_ACT_WIDE_ON = 9'h080,
		CV2_ACT_WIDE_OFF = 9'h100
	} cv2_action_t;
	typedef struct packed {
		cv2_action_t kind;
		logic [7:0] data;
	} cv2_msg_t;
	typedef struct packed {
		logic [7:0] cfg2;
		logic [7:0] cfg3;
		logic four_wide;
		logic addr4;
	} cv2_snap_t;
	typedef struct packed {
		logic line3_write_protect;
		logic line4_reset;
		logic single_read_ok;
		logic dual_read_ok;
		logic quad_read_ok;
	} cv2_roles_t;
endpackage

/* cv2_config2_volatile.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cv2_consts.svh"
module cv2_config2_volatile (
	input wire logic mclk,
	input wire logic reset,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input wire logic [7:0] config2_nonvolatile,
	input wire logic [7:0] config3_nonvolatile,
	input wire logic config1_quad_enable,
	input wire logic nv_addr_len_written,
	input wire logic soft_reset_req,
	input wire logic read_is_main_array,
	output logic [7:0] config2_volatile,
	output logic [7:0] config3_volatile,
	output logic [1:0] drive_strength,
	output logic four_wide_instruction_mode,
	output logic quad_active,
	output logic protect_method_select,
	output logic addr_len_current,
	output logic addr_len_boot_view,
	output logic line4_alt_reset_select,
	output cv2_pkg::cv2_roles_t roles,
	output logic line4_reset_request,
	output logic wrap_active
);
	// Link side, clocked by sck; frame state is cleared by chip select
	cv2_pkg::cv2_snap_t snap, snap_meta, snap_sync;
	cv2_pkg::cv2_phase_t phase;
	cv2_pkg::cv2_msg_t act_msg, next_msg;
	logic act_toggle;
	logic [1:0] edge_idx;
	logic wide;
	logic [7:0] early, sh, next_sh, byte_val, cmd, dummy_left, tx;
	logic [3:0] bits, next_bits;
	logic byte_done, post;
	logic [2:0] addr_left, rd_pos;
	logic [31:0] addr;
	logic [1:0] data_idx;

	function automatic logic [7:0] cv2_read_any(input logic [31:0] a, input cv2_pkg::cv2_snap_t s);
		if (a == `CV2_REGADDR_CONFIG2) begin
			return s.cfg2;
		end else if (a == `CV2_REGADDR_CONFIG3) begin
			return s.cfg3;
		end else begin
			return 8'h00;
		end
	endfunction

	// Snapshot is frozen while a frame runs, so the word is stable when sampled
	always_ff @(posedge sck or posedge reset) begin
		if (reset) begin
			snap_meta <= '0;
			snap_sync <= '0;
		end else begin
			snap_meta <= snap;
			snap_sync <= snap_meta;
		end
	end

	// Width is decided at the third edge, once the mode has crossed over
	always_comb begin
		next_sh = sh;
		next_bits = bits;
		byte_done = 1'b0;
		byte_val = sh;
		if (edge_idx == `CV2_LOCK_EDGE) begin
			if (snap_sync.four_wide) begin
				byte_done = 1'b1; // [R4]
				byte_val = early;
				next_sh = {4'h0, io_in};
				next_bits = 4'h4;
			end else begin
				next_sh = {5'h00, early[4], early[0], io_in[0]}; // [R4]
				next_bits = 4'h3;
			end
		end else if (edge_idx == 2'h3) begin
			if (wide) begin
				next_sh = {sh[3:0], io_in};
				next_bits = bits + 4'h4;
			end else begin
				next_sh = {sh[6:0], io_in[0]};
				next_bits = bits + 4'h1;
			end
			if (next_bits == 4'h8) begin
				byte_done = 1'b1;
				byte_val = next_sh;
				next_bits = 4'h0;
			end
		end
	end

	always_comb begin
		post = 1'b0;
		next_msg.kind = cv2_pkg::CV2_ACT_NONE;
		next_msg.data = byte_val;
		if (byte_done && phase == cv2_pkg::CV2_PH_INSTR) begin
			post = 1'b1;
			case (byte_val)
				`CV2_OP_WREN_VOLATILE: next_msg.kind = cv2_pkg::CV2_ACT_WREN; // [R16]
				`CV2_OP_ADDR4_ENTER: next_msg.kind = cv2_pkg::CV2_ACT_ADDR4_ON; // [R14]
				`CV2_OP_ADDR4_EXIT: next_msg.kind = cv2_pkg::CV2_ACT_ADDR4_OFF; // [R14]
				`CV2_OP_WIDE_ENTER: next_msg.kind = cv2_pkg::CV2_ACT_WIDE_ON; // [R7]
				`CV2_OP_WIDE_EXIT: next_msg.kind = cv2_pkg::CV2_ACT_WIDE_OFF; // [R7]
				default: post = 1'b0;
			endcase
		end else if (byte_done && phase == cv2_pkg::CV2_PH_DATA) begin
			if (cmd == `CV2_OP_WRITE_REGS) begin
				if (data_idx == `CV2_WRR_IDX_CFG2) begin
					post = 1'b1; // [R16]
					next_msg.kind = cv2_pkg::CV2_ACT_CFG2;
				end else if (data_idx == `CV2_WRR_IDX_CFG3) begin
					post = 1'b1; // [R19]
					next_msg.kind = cv2_pkg::CV2_ACT_CFG3;
				end
			end else if (cmd == `CV2_OP_WRITE_ANY && data_idx == 2'h0) begin
				if (addr == `CV2_REGADDR_CONFIG2) begin
					post = 1'b1; // [R16]
					next_msg.kind = cv2_pkg::CV2_ACT_CFG2;
				end else if (addr == `CV2_REGADDR_CONFIG3) begin
					post = 1'b1; // [R19]
					next_msg.kind = cv2_pkg::CV2_ACT_CFG3;
				end
			end else if (cmd == `CV2_OP_BURST_LEN && data_idx == 2'h0) begin
				post = 1'b1; // [R19]
				next_msg.kind = cv2_pkg::CV2_ACT_BURST;
			end
		end
	end

	// Message is held until the next byte, well past the toggle crossing time
	always_ff @(posedge sck or posedge reset) begin
		if (reset) begin
			act_toggle <= 1'b0;
			act_msg <= '{kind: cv2_pkg::CV2_ACT_NONE, data: 8'h00};
		end else if (!cs_n && post) begin
			act_toggle <= ~act_toggle;
			act_msg <= next_msg;
		end
	end

	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			edge_idx <= 2'h0;
			wide <= 1'b0;
			early <= 8'h00;
			sh <= 8'h00;
			bits <= 4'h0;
			phase <= cv2_pkg::CV2_PH_INSTR;
			cmd <= 8'h00;
			addr_left <= 3'h0;
			addr <= 32'h00000000;
			dummy_left <= 8'h00;
			data_idx <= 2'h0;
			tx <= 8'h00;
			rd_pos <= 3'h0;
		end else begin
			if (edge_idx != 2'h3) begin
				edge_idx <= edge_idx + 2'h1;
			end
			if (edge_idx < `CV2_LOCK_EDGE) begin
				early <= {early[3:0], io_in};
			end
			if (edge_idx == `CV2_LOCK_EDGE) begin
				wide <= snap_sync.four_wide; // [R4]
			end
			sh <= next_sh;
			bits <= next_bits;
			case (phase)
				cv2_pkg::CV2_PH_INSTR: begin
					if (byte_done) begin
						cmd <= byte_val;
						addr_left <= snap_sync.addr4 ? `CV2_ADDR_BYTES_4 : `CV2_ADDR_BYTES_3; // [R13]
						if (byte_val == `CV2_OP_READ_CFG2) begin
							tx <= snap_sync.cfg2; // [R16]
							phase <= cv2_pkg::CV2_PH_READ;
						end else if (byte_val == `CV2_OP_READ_CFG3) begin
							tx <= snap_sync.cfg3; // [R19]
							phase <= cv2_pkg::CV2_PH_READ;
						end else if (byte_val == `CV2_OP_READ_ANY || byte_val == `CV2_OP_WRITE_ANY) begin
							phase <= cv2_pkg::CV2_PH_ADDR;
						end else if (byte_val == `CV2_OP_WRITE_REGS || byte_val == `CV2_OP_BURST_LEN) begin
							phase <= cv2_pkg::CV2_PH_DATA;
						end else begin
							phase <= cv2_pkg::CV2_PH_IGNORE;
						end
					end
				end
				cv2_pkg::CV2_PH_ADDR: begin
					if (byte_done) begin
						addr <= {addr[23:0], byte_val};
						addr_left <= addr_left - 3'h1;
						dummy_left <= `CV2_READ_ANY_DUMMY;
						if (addr_left == 3'h1) begin
							phase <= (cmd == `CV2_OP_READ_ANY) ? cv2_pkg::CV2_PH_DUMMY :
								cv2_pkg::CV2_PH_DATA;
						end
					end
				end
				cv2_pkg::CV2_PH_DUMMY: begin
					dummy_left <= dummy_left - 8'h01;
					if (dummy_left == 8'h01) begin
						tx <= cv2_read_any(addr, snap_sync); // [R16]
						phase <= cv2_pkg::CV2_PH_READ;
					end
				end
				cv2_pkg::CV2_PH_DATA: begin
					if (byte_done && data_idx != 2'h3) begin
						data_idx <= data_idx + 2'h1;
					end
				end
				cv2_pkg::CV2_PH_READ: begin
					rd_pos <= rd_pos + (wide ? 3'h4 : 3'h1);
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads repeat the same byte until chip select rises
	always_ff @(negedge sck or posedge cs_n or posedge reset) begin
		if (cs_n || reset) begin
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end else if (phase == cv2_pkg::CV2_PH_READ) begin
			if (wide) begin
				io_out <= rd_pos[2] ? tx[3:0] : tx[7:4]; // [R4]
				io_oe <= 4'hF;
			end else begin
				io_out <= {2'h0, tx[3'h7 - rd_pos], 1'h0};
				io_oe <= 4'h2;
			end
		end else begin
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end
	end

	// Controller side, on mclk
	logic cs_meta, cs_sync, cs_prev, io3_meta, io3_sync;
	logic tog_meta, tog_sync, tog_seen, fire, wren, frame_wrote, write_fire, line4_hit, reload;
	logic [7:0] cfg2, cfg3;
	logic line4_role;

	always_ff @(posedge mclk) begin
		if (reset) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_prev <= 1'b1;
			io3_meta <= 1'b1;
			io3_sync <= 1'b1;
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_seen <= 1'b0;
		end else begin
			cs_meta <= cs_n;
			cs_sync <= cs_meta;
			cs_prev <= cs_sync;
			io3_meta <= io_in[3];
			io3_sync <= io3_meta;
			tog_meta <= act_toggle;
			tog_sync <= tog_meta;
			tog_seen <= tog_sync;
		end
	end

	assign fire = tog_sync ^ tog_seen;
	assign write_fire = fire && wren &&
		(act_msg.kind == cv2_pkg::CV2_ACT_CFG2 || act_msg.kind == cv2_pkg::CV2_ACT_CFG3);
	assign quad_active = cfg2[`CV2_BIT_FOUR_WIDE] | config1_quad_enable; // [R5] [R6]
	assign line4_role = cfg2[`CV2_BIT_ALT_RESET] &
		(cs_sync | ~quad_active | ~cfg2[`CV2_BIT_FOUR_WIDE]); // [R1] [R2]
	assign line4_hit = line4_role & ~io3_sync; // [R1]
	assign reload = reset | soft_reset_req | line4_hit;

	always_ff @(posedge mclk) begin
		if (reload) begin
			cfg2 <= {config2_nonvolatile[7:1], config2_nonvolatile[`CV2_NV_BIT_ADDR]} & `CV2_CFG2_WRITE_MASK; // [R21] [R13] [R22]
		end else begin
			if (write_fire && act_msg.kind == cv2_pkg::CV2_ACT_CFG2) begin
				cfg2 <= act_msg.data & `CV2_CFG2_WRITE_MASK; // [R3] [R11] [R22] [R20]
			end else if (fire && act_msg.kind == cv2_pkg::CV2_ACT_ADDR4_ON) begin
				cfg2[`CV2_BIT_ADDR_CUR] <= 1'b1; // [R14]
			end else if (fire && act_msg.kind == cv2_pkg::CV2_ACT_ADDR4_OFF) begin
				cfg2[`CV2_BIT_ADDR_CUR] <= 1'b0; // [R14]
			end else if (fire && act_msg.kind == cv2_pkg::CV2_ACT_WIDE_ON) begin
				cfg2[`CV2_BIT_FOUR_WIDE] <= 1'b1; // [R7] [R20]
			end else if (fire && act_msg.kind == cv2_pkg::CV2_ACT_WIDE_OFF) begin
				cfg2[`CV2_BIT_FOUR_WIDE] <= 1'b0; // [R7] [R6] [R20]
			end
			if (nv_addr_len_written) begin
				cfg2[`CV2_BIT_ADDR_CUR] <= config2_nonvolatile[`CV2_NV_BIT_ADDR]; // [R15]
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reload) begin
			cfg3 <= config3_nonvolatile; // [R18]
		end else if (write_fire && act_msg.kind == cv2_pkg::CV2_ACT_CFG3) begin
			cfg3 <= act_msg.data; // [R19]
		end else if (fire && act_msg.kind == cv2_pkg::CV2_ACT_BURST) begin
			cfg3 <= act_msg.data; // [R19]
		end
	end

	// Enable survives a whole frame so one write-registers frame may hit both bytes
	always_ff @(posedge mclk) begin
		if (reload) begin
			wren <= 1'b0;
			frame_wrote <= 1'b0;
		end else begin
			if (fire && act_msg.kind == cv2_pkg::CV2_ACT_WREN) begin
				wren <= 1'b1; // [R16]
			end else if (cs_sync && !cs_prev && (frame_wrote || write_fire)) begin
				wren <= 1'b0;
			end
			if (write_fire) begin
				frame_wrote <= 1'b1;
			end else if (cs_sync && !cs_prev) begin
				frame_wrote <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			snap <= '0;
			line4_reset_request <= 1'b0;
		end else begin
			if (cs_sync) begin
				snap <= '{cfg2: config2_volatile, cfg3: cfg3, four_wide: cfg2[`CV2_BIT_FOUR_WIDE],
					addr4: cfg2[`CV2_BIT_ADDR_CUR]};
			end
			line4_reset_request <= line4_hit; // [R1]
		end
	end

	assign config2_volatile = {cfg2[7:5], 1'b0, cfg2[3:2],
		config2_nonvolatile[`CV2_NV_BIT_ADDR], cfg2[0]}; // [R12] [R22]
	assign config3_volatile = cfg3;
	assign drive_strength = cfg2[`CV2_BIT_DRIVE_HI:`CV2_BIT_DRIVE_LO]; // [R3]
	assign four_wide_instruction_mode = cfg2[`CV2_BIT_FOUR_WIDE]; // [R4]
	assign protect_method_select = cfg2[`CV2_BIT_PROTECT]; // [R11]
	assign addr_len_current = cfg2[`CV2_BIT_ADDR_CUR]; // [R13]
	assign addr_len_boot_view = config2_nonvolatile[`CV2_NV_BIT_ADDR]; // [R12]
	assign line4_alt_reset_select = cfg2[`CV2_BIT_ALT_RESET];
	assign roles.line3_write_protect = ~quad_active; // [R8] [R9] [R10]
	assign roles.line4_reset = line4_role; // [R8] [R9] [R10]
	assign roles.single_read_ok = ~cfg2[`CV2_BIT_FOUR_WIDE]; // [R8] [R10]
	assign roles.dual_read_ok = ~cfg2[`CV2_BIT_FOUR_WIDE]; // [R8] [R10]
	assign roles.quad_read_ok = quad_active; // [R9] [R10]
	assign wrap_active = ~cfg3[`CV2_CFG3_BIT_WRAP_OFF] & read_is_main_array; // [R17]

	AST_ALT_RESET_ON: assert property (@(posedge mclk) disable iff (reset) // [R1]
		cfg2[7] && cs_sync && !io3_sync |=> line4_reset_request && cfg3 == $past(config3_nonvolatile))
		else $error("line four reset not honoured");
	AST_ALT_RESET_OFF: assert property (@(posedge mclk) disable iff (reset) // [R2]
		!cfg2[7] |-> !roles.line4_reset)
		else $error("line four reset active while disabled");
	AST_QUAD_FORCED: assert property (@(posedge mclk) disable iff (reset) // [R5]
		four_wide_instruction_mode |-> quad_active && roles.quad_read_ok && !roles.dual_read_ok)
		else $error("four-wide mode without quad mode");
	AST_WIDE_ENTER: assert property (@(posedge mclk) disable iff (reset) // [R7]
		fire && act_msg.kind == cv2_pkg::CV2_ACT_WIDE_ON && !soft_reset_req && !line4_hit
		|=> four_wide_instruction_mode)
		else $error("enter command did not set four-wide mode");
	AST_WIDE_EXIT: assert property (@(posedge mclk) disable iff (reset) // [R7]
		fire && act_msg.kind == cv2_pkg::CV2_ACT_WIDE_OFF && !soft_reset_req
		|=> !four_wide_instruction_mode)
		else $error("exit command did not clear four-wide mode");
	AST_LEGACY_ROLES: assert property (@(posedge mclk) disable iff (reset) // [R8]
		!cfg2[3] && !config1_quad_enable |-> roles.line3_write_protect && !roles.quad_read_ok)
		else $error("legacy pin roles wrong");
	AST_BOOT_VIEW: assert property (@(posedge mclk) disable iff (reset) // [R12]
		config2_volatile[1] == config2_nonvolatile[1])
		else $error("boot address view mismatch");
	AST_ADDR4_ENTER: assert property (@(posedge mclk) disable iff (reset) // [R14]
		fire && act_msg.kind == cv2_pkg::CV2_ACT_ADDR4_ON && !reload && !nv_addr_len_written
		|=> addr_len_current ##1 addr_len_current || $past(reload) || $past(fire))
		else $error("four byte address not entered");
	AST_NV_FOLLOW: assert property (@(posedge mclk) disable iff (reset) // [R15]
		nv_addr_len_written && !reload |=> addr_len_current == $past(config2_nonvolatile[1]))
		else $error("current length did not follow nonvolatile");
	AST_RELOAD_CFG3: assert property (@(posedge mclk) disable iff (reset) // [R18]
		soft_reset_req |=> config3_volatile == $past(config3_nonvolatile) && !wren)
		else $error("config three not reloaded");
	AST_RELOAD_CFG2: assert property (@(posedge mclk) disable iff (reset) // [R21]
		soft_reset_req |=> config2_volatile[7:2] == ($past(config2_nonvolatile[7:2]) & 6'h3B))
		else $error("config two not reloaded");
	AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (reset) // [R22]
		write_fire && act_msg.kind == cv2_pkg::CV2_ACT_CFG2 && !reload |=> !config2_volatile[4]
		&& drive_strength == $past(act_msg.data[6:5]))
		else $error("reserved bit or drive field wrong after write");
	AST_WRAP_ARRAY: assert property (@(posedge mclk) disable iff (reset) // [R17]
		!read_is_main_array |-> !wrap_active)
		else $error("wrap applied outside main array");
endmodule
`default_nettype wire

/* cv2_host.sv */
`timescale 1ns/100ps
`default_nettype none
module cv2_host (
	input wire logic quad,
	output logic sck,
	output logic cs_n,
	output logic [3:0] io,
	input wire logic [3:0] io_out,
	input wire logic [3:0] io_oe
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		io = 4'hA;
	end
	// Serial clock stands low between frames; start offset keeps it off the mclk phase
	task automatic frame(input logic [63:0] tx, input int nbits, input int nrd,
		output logic [7:0] rx);
		int i;
		rx = 8'h00;
		#($urandom_range(70, 10));
		cs_n = 1'b0;
		for (i = nbits - 1; i >= 0; i = i - (quad ? 4 : 1)) begin
			io = quad ? tx[i-:4] : {1'b1, ~io[2:1], tx[i]};
			#80 sck = 1'b1;
			#80 sck = 1'b0;
		end
		// Released lines toggle so stale data never passes; line four keeps its pull-up in single mode, toggles in quad
		for (i = 0; i < nrd; i++) begin
			io = quad ? ~io : {1'b1, ~io[2:0]};
			#80 sck = 1'b1;
			rx = quad ? {rx[3:0], io_out} : {rx[6:0], io_out[1]};
			#80 sck = 1'b0;
		end
		#40 cs_n = 1'b1;
		io = {1'b1, ~io[2:0]};
		#40;
	endtask
endmodule
`default_nettype wire

/* tb_serial_flash_volatile_config2.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_serial_flash_volatile_config2;
	logic mclk, reset, sck, cs_n, quad_enable, nv_written, soft_reset, main_rd, rst4_n, quad;
	logic [3:0] host_io, io_in, io_out, io_oe;
	logic [7:0] nv2, nv3, cfg2, cfg3, m2, m3, rx, d;
	logic [1:0] drv;
	logic fw, qa, pm, alc, abv, alt, l4req, wrap;
	cv2_pkg::cv2_roles_t roles;
	int num_errors, n_tests, cycles;

	// Wire level: device drives where enabled, line four may be pulled low by the system
	assign io_in = ((io_oe & io_out) | (~io_oe & host_io)) & {rst4_n, 3'h7};

	cv2_config2_volatile dut (.mclk(mclk), .reset(reset), .sck(sck), .cs_n(cs_n),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe), .config2_nonvolatile(nv2),
		.config3_nonvolatile(nv3), .config1_quad_enable(quad_enable),
		.nv_addr_len_written(nv_written), .soft_reset_req(soft_reset),
		.read_is_main_array(main_rd), .config2_volatile(cfg2), .config3_volatile(cfg3),
		.drive_strength(drv), .four_wide_instruction_mode(fw), .quad_active(qa),
		.protect_method_select(pm), .addr_len_current(alc), .addr_len_boot_view(abv),
		.line4_alt_reset_select(alt), .roles(roles), .line4_reset_request(l4req),
		.wrap_active(wrap));

	cv2_host host (.quad(quad), .sck(sck), .cs_n(cs_n), .io(host_io), .io_out(io_out),
		.io_oe(io_oe));

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic test_done;
		if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 50000) begin
			num_errors = num_errors + 1;
			test_done;
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] view();
		return m2 | {6'h00, nv2[1], 1'b0};
	endfunction

	task automatic check_all;
		logic [7:0] v;
		logic q;
		v = view();
		q = v[3] | quad_enable;
		cmp({cfg2, cfg3, drv, fw, pm, alc, abv, alt},
			{v, m3, v[6:5], v[3], v[2], v[0], nv2[1], v[7]});
		cmp({qa, roles, wrap},
			{q, ~q, v[7], ~v[3], ~v[3], q, ~m3[4] & main_rd});
	endtask

	task automatic cmd(input logic [63:0] tx, input int nbits, input int nrd);
		host.frame(tx, nbits, nrd, rx);
		repeat (12) @(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] v, input logic en);
		if (en) cmd(64'h50, 8, 0);
		cmd({8'h01, 16'h0000, v, m3}, 40, 0);
		if (en) m2 = v & 8'hED;
	endtask

	task automatic wany(input logic [7:0] v);
		cmd(64'h50, 8, 0);
		if (m2[0]) cmd({8'h71, 32'h00800003, v}, 48, 0);
		else cmd({8'h71, 24'h800003, v}, 40, 0);
		m2 = v & 8'hED;
	endtask

	task automatic rd_any;
		if (m2[0]) cmd({8'h65, 32'h00800003}, 40, 16);
		else cmd({8'h65, 24'h800003}, 32, 16);
		cmp(rx, view());
	endtask

	task automatic l4_pulse(input logic exp);
		int i;
		logic seen;
		seen = 1'b0;
		rst4_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst4_n <= 1'b1;
		for (i = 0; i < 8; i++) begin
			@(posedge mclk);
			seen = seen | l4req;
		end
		cmp(seen, exp);
	endtask

	initial begin
		int i;
		void'($urandom(32'h1d88));
		{quad, quad_enable, nv_written, soft_reset, main_rd, rst4_n} = 6'h01;
		// Rise after the flops are armed, so the link-side async clear is seen
		reset <= 1'b1;
		{num_errors, n_tests, cycles} = 0;
		nv2 = $urandom & 8'h77;
		nv3 = $urandom;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		m2 = {nv2[7:1], nv2[1]} & 8'hED;
		m3 = nv3;
		repeat (4) @(posedge mclk);
		check_all;
		d = $urandom & 8'h77;
		wr(d, 1'b0);
		check_all;
		wr(d, 1'b1);
		check_all;
		wr(~d & 8'h77, 1'b0);
		check_all;
		wany(~d & 8'h77);
		check_all;
		cmd(64'h15, 8, 8);
		cmp(rx, view());
		cmd(64'hB7, 8, 0);
		m2[0] = 1'b1;
		check_all;
		rd_any;
		cmd(64'hE9, 8, 0);
		m2[0] = 1'b0;
		rd_any;
		d = $urandom;
		cmd({8'h77, d}, 16, 0);
		m3 = d;
		for (i = 0; i < 2; i++) begin
			main_rd <= i[0];
			@(posedge mclk);
			check_all;
		end
		cmd(64'h33, 8, 8);
		cmp(rx, m3);
		for (i = 0; i < 2; i++) begin
			quad_enable <= i[0];
			@(posedge mclk);
			check_all;
			cmd(64'h38, 8, 0);
			m2[3] = 1'b1;
			quad = 1'b1;
			check_all;
			cmd(64'h15, 8, 3);
			cmp(rx, view());
			// Width is only known at the third edge, so a lone quad opcode needs a spare clock
			cmd(64'hF5, 8, 1);
			m2[3] = 1'b0;
			quad = 1'b0;
			check_all;
		end
		nv2 <= nv2 ^ 8'h02;
		nv_written <= 1'b1;
		@(posedge mclk);
		nv_written <= 1'b0;
		m2[0] = nv2[1];
		repeat (4) @(posedge mclk);
		check_all;
		wany(8'h64);
		soft_reset <= 1'b1;
		@(posedge mclk);
		soft_reset <= 1'b0;
		m2 = {nv2[7:1], nv2[1]} & 8'hED;
		m3 = nv3;
		repeat (4) @(posedge mclk);
		check_all;
		wr(8'h65, 1'b1);
		l4_pulse(1'b0);
		check_all;
		wr(8'hE5, 1'b1);
		l4_pulse(1'b1);
		m2 = {nv2[7:1], nv2[1]} & 8'hED;
		m3 = nv3;
		check_all;
		test_done;
	end
endmodule
`default_nettype wire
